// *** hw/ms_pkg.sv ***
// Package with the constants and types of the switch update block.
package ms_pkg;

  // ****************************************************************
  // Bus address and bit timing.
  // ****************************************************************
  localparam logic [3:0] MS_ADDR_HI   = 4'ha;
  localparam logic [3:0] MS_BIT_LAST  = 4'h7;
  localparam logic [3:0] MS_BIT_ACK   = 4'h8;
  localparam logic [3:0] MS_BIT_FIRST = 4'h0;

  // ****************************************************************
  // Command codes of the select field.
  // ****************************************************************
  localparam logic [6:0] MS_CMD_ALL_A   = 7'h00;
  localparam logic [6:0] MS_CMD_ALL_B   = 7'h01;
  localparam logic [6:0] MS_CMD_SW_LO   = 7'h02;
  localparam logic [6:0] MS_CMD_SW_HI   = 7'h09;
  localparam logic [6:0] MS_CMD_DIS1    = 7'h0e;
  localparam logic [6:0] MS_CMD_DIS2    = 7'h0f;
  localparam logic [6:0] MS_CMD_DIS3    = 7'h10;
  localparam logic [6:0] MS_CMD_DIS4    = 7'h11;
  localparam logic [6:0] MS_CMD_GPO     = 7'h14;
  localparam logic [6:0] MS_CMD_ALL_OFF = 7'h1f;

  // ****************************************************************
  // Field positions and reset values.
  // ****************************************************************
  localparam int         MS_LEVEL_POS   = 7;
  localparam int         MS_LOAD_POS    = 0;
  localparam int         MS_RESET_POS   = 1;
  localparam int         MS_GPO_STAT    = 3;
  localparam int         MS_NSW         = 8;
  localparam logic [7:0] MS_SW_RST      = 8'h00;
  localparam logic       MS_GPO_RST     = 1'b0;
  localparam logic [15:0] MS_STAT_RST   = 16'h0000;

  // ****************************************************************
  // Phases of the link engine.
  // ****************************************************************
  typedef enum logic [2:0] {
    PH_ADDR = 3'b000,
    PH_CMD  = 3'b001,
    PH_CTRL = 3'b010,
    PH_READ = 3'b011,
    PH_IDLE = 3'b100
  } ms_phase_t;

endpackage

// *** hw/ms_link.sv ***
// Serial engine of the switch block, clocked by the bus clock.
`timescale 1ns/1ps
module ms_link
  import ms_pkg::*;
(
  // Link clock, frame clear and system reset.
  input  wire logic        scl_i,
  input  wire logic        link_clr_i,
  input  wire logic        rst_i,
  // Data pin.
  input  wire logic        sda_i,
  output logic             sda_oe_o,
  // Address select and status word.
  input  wire logic [2:0]  addr_sel_i,
  input  wire logic [15:0] status_i,
  // Received command word.
  output logic [15:0]      word_o,
  output logic             word_tgl_o
);

  ms_phase_t   phase_r, phase_nxt;
  logic [3:0]  bcnt_r, bcnt_nxt;
  logic [7:0]  sh_r, sh_nxt;
  logic [7:0]  cmd_r, cmd_nxt;
  logic [15:0] word_r, word_nxt;
  logic        tgl_r, tgl_nxt;
  logic        ack_r, ack_nxt;
  logic        rd_idx_r, rd_idx_nxt;
  logic        oe_r, oe_nxt;
  logic [7:0]  byte_in;
  logic        tx_bit;

  // ****************************************************************
  // Byte reception on the rising clock edge.
  // ****************************************************************
  always_comb begin
    phase_nxt  = phase_r;
    bcnt_nxt   = bcnt_r;
    sh_nxt     = sh_r;
    cmd_nxt    = cmd_r;
    word_nxt   = word_r;
    tgl_nxt    = tgl_r;
    ack_nxt    = ack_r;
    rd_idx_nxt = rd_idx_r;
    byte_in    = {sh_r[6:0], sda_i};
    if (bcnt_r == MS_BIT_ACK) begin
      bcnt_nxt = MS_BIT_FIRST;
      ack_nxt  = 1'b0;
      if (phase_r == PH_READ && !ack_r) begin
        if (sda_i) begin
          phase_nxt = PH_IDLE;
        end else begin
          rd_idx_nxt = ~rd_idx_r;
        end
      end
    end else begin
      bcnt_nxt = bcnt_r + 4'h1;
      sh_nxt   = byte_in;
      if (bcnt_r == MS_BIT_LAST) begin
        case (phase_r)
          PH_ADDR: begin
            if (byte_in[7:1] == {MS_ADDR_HI, addr_sel_i}) begin
              ack_nxt   = 1'b1;
              phase_nxt = byte_in[0] ? PH_READ : PH_CMD;
            end else begin
              phase_nxt = PH_IDLE;
            end
          end
          PH_CMD: begin
            ack_nxt   = 1'b1;
            cmd_nxt   = byte_in;
            phase_nxt = PH_CTRL;
          end
          PH_CTRL: begin
            ack_nxt   = 1'b1;
            word_nxt  = {cmd_r, byte_in};
            tgl_nxt   = ~tgl_r;
            phase_nxt = PH_CMD;
          end
          default: begin
            phase_nxt = phase_r;
          end
        endcase
      end
    end
  end

  always_ff @(posedge scl_i or posedge link_clr_i) begin
    if (link_clr_i) begin
      phase_r  <= PH_ADDR;
      bcnt_r   <= MS_BIT_FIRST;
      sh_r     <= 8'h00;
      cmd_r    <= 8'h00;
      ack_r    <= 1'b0;
      rd_idx_r <= 1'b0;
    end else begin
      phase_r  <= phase_nxt;
      bcnt_r   <= bcnt_nxt;
      sh_r     <= sh_nxt;
      cmd_r    <= cmd_nxt;
      ack_r    <= ack_nxt;
      rd_idx_r <= rd_idx_nxt;
    end
  end

  // The word and its toggle survive the frame clear, not the reset.
  always_ff @(posedge scl_i or posedge rst_i) begin
    if (rst_i) begin
      word_r <= 16'h0000;
      tgl_r  <= 1'b0;
    end else begin
      word_r <= word_nxt;
      tgl_r  <= tgl_nxt;
    end
  end

  // ****************************************************************
  // Pin drive on the falling clock edge.
  // ****************************************************************
  always_comb begin
    tx_bit = status_i[{~rd_idx_r, ~bcnt_r[2:0]}];
    oe_nxt = (bcnt_r == MS_BIT_ACK && ack_r) ||
             (phase_r == PH_READ && bcnt_r < MS_BIT_ACK && !tx_bit);
  end

  always_ff @(negedge scl_i or posedge link_clr_i) begin
    if (link_clr_i) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= oe_nxt;
    end
  end

  assign sda_oe_o   = oe_r;
  assign word_o     = word_r;
  assign word_tgl_o = tgl_r;

endmodule

// *** hw/ms_switch_top.sv ***
// Top level of the switch update and readback block.
//
// Behaviour
// - Commands accumulate and apply together at each write with load strobe set and soft reset high.
// - A write with load strobe set and soft reset high applies its own command straight away.
// - At update all switches and output pin change in the same cycle.
// - Soft reset low or power-up opens all switches, output pin low.
// - Read starts with address byte, read bit set; device acknowledges low.
// - After address acknowledge device sends two status bytes; master acknowledges the first, not the second.
// - Status reports a closed switch as one, an open one as zero.
// - Status bit 3 shows output pin level; unused on variant without it.
// - Switches occupy status bits 15 to 8, output pin bit 3.
// - A write is address byte then command byte then control byte.
// - Command top bit gives level (disable codes force it off), low seven bits select the target.
// - Several pending commands on one target: only the last applies.
// - Bus address is four fixed upper bits plus three select pins.
`timescale 1ns/1ps
module ms_switch_top
  import ms_pkg::*;
#(
  parameter int   LOAD_POS  = MS_LOAD_POS,
  parameter int   RESET_POS = MS_RESET_POS,
  parameter logic HAS_GPO   = 1'b1
)
(
  // System clock and reset.
  input  wire logic       MCLK_I,
  input  wire logic       RST_I,
  // Serial bus pins.
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE_O,
  // Address select pins.
  input  wire logic [2:0] ADDR_SEL_I,
  // Switch controls and general output.
  output logic [7:0]      SW_CLOSED_O,
  output logic            GENERAL_OUTPUT_O
);

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  logic        rst_m1_r;
  logic        rst_m1_nxt;
  logic        rst_m2_r;
  logic        rst_m2_nxt;
  logic        scl_m1_r;
  logic        scl_m2_r;
  logic        sda_m1_r;
  logic        sda_m2_r;
  logic        sda_m3_r;
  logic [2:0]  sel_m1_r;
  logic [2:0]  sel_m2_r;
  logic        tgl_m1_r;
  logic        tgl_m2_r;
  logic        tgl_m3_r;
  logic        link_clr_r;
  logic        link_clr_nxt;
  logic        in_frame_r;
  logic        in_frame_nxt;
  logic [15:0] status_x_r;
  logic [15:0] status_x_nxt;
  logic [7:0]  pend_val_r;
  logic [7:0]  pend_val_nxt;
  logic [7:0]  pend_vld_r;
  logic [7:0]  pend_vld_nxt;
  logic        pgpo_val_r;
  logic        pgpo_val_nxt;
  logic        pgpo_vld_r;
  logic        pgpo_vld_nxt;
  logic [7:0]  sw_r;
  logic [7:0]  sw_nxt;
  logic        gpo_r;
  logic        gpo_nxt;
  logic [7:0]  sw_rev;
  logic [15:0] status_w;
  logic [15:0] link_word;
  logic        link_tgl;
  logic        start_evt;
  logic        stop_evt;
  logic        cmd_evt;
  logic [8:0]  mask;
  logic        lvl;

  // ****************************************************************
  // Command decoding.
  // ****************************************************************
  // Bits 7..0 select switches (0 is mux1 input A), bit 8 the output.
  function automatic logic [8:0] target_mask(input logic [7:0] cmd);
    logic [6:0] sel;
    logic [8:0] m;
    sel = cmd[6:0];
    m   = 9'h000;
    if (sel == MS_CMD_ALL_A) begin
      m = 9'h055;
    end else if (sel == MS_CMD_ALL_B) begin
      m = 9'h0aa;
    end else if (sel >= MS_CMD_SW_LO && sel <= MS_CMD_SW_HI) begin
      m[3'(sel - MS_CMD_SW_LO)] = 1'b1;
    end else if (sel == MS_CMD_DIS1) begin
      m = 9'h003;
    end else if (sel == MS_CMD_DIS2) begin
      m = 9'h00c;
    end else if (sel == MS_CMD_DIS3) begin
      m = 9'h030;
    end else if (sel == MS_CMD_DIS4) begin
      m = 9'h0c0;
    end else if (sel == MS_CMD_GPO) begin
      m = {HAS_GPO, 8'h00};
    end else if (sel == MS_CMD_ALL_OFF && !cmd[MS_LEVEL_POS]) begin
      m = 9'h0ff;
    end
    return m;
  endfunction

  // Disable codes force the level off whatever the top bit says.
  function automatic logic target_level(input logic [7:0] cmd);
    logic [6:0] sel;
    logic       l;
    sel = cmd[6:0];
    l   = cmd[MS_LEVEL_POS];
    if (sel >= MS_CMD_DIS1 && sel <= MS_CMD_DIS4) begin
      l = 1'b0;
    end
    return l;
  endfunction

  // ****************************************************************
  // Link engine on the bus clock.
  // ****************************************************************
  ms_link u_link (
    .scl_i      (SCL_I),
    .link_clr_i (link_clr_r),
    .rst_i      (rst_m2_r),
    .sda_i      (SDA_I),
    .sda_oe_o   (SDA_OE_O),
    .addr_sel_i (sel_m2_r),
    .status_i   (status_x_r),
    .word_o     (link_word),
    .word_tgl_o (link_tgl)
  );

  // ****************************************************************
  // Reset release synchroniser.
  // ****************************************************************
  // Reset takes effect at once and is released in step with the clock.
  always_comb begin
    rst_m1_nxt = 1'b0;
    rst_m2_nxt = rst_m1_r;
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      rst_m1_r <= 1'b1;
      rst_m2_r <= 1'b1;
    end else begin
      rst_m1_r <= rst_m1_nxt;
      rst_m2_r <= rst_m2_nxt;
    end
  end

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  always_ff @(posedge MCLK_I or posedge rst_m2_r) begin
    if (rst_m2_r) begin
      scl_m1_r <= 1'b1;
      scl_m2_r <= 1'b1;
      sda_m1_r <= 1'b1;
      sda_m2_r <= 1'b1;
      sda_m3_r <= 1'b1;
      sel_m1_r <= 3'h0;
      sel_m2_r <= 3'h0;
      tgl_m1_r <= 1'b0;
      tgl_m2_r <= 1'b0;
      tgl_m3_r <= 1'b0;
    end else begin
      scl_m1_r <= SCL_I;
      scl_m2_r <= scl_m1_r;
      sda_m1_r <= SDA_I;
      sda_m2_r <= sda_m1_r;
      sda_m3_r <= sda_m2_r;
      sel_m1_r <= ADDR_SEL_I;
      sel_m2_r <= sel_m1_r;
      tgl_m1_r <= link_tgl;
      tgl_m2_r <= tgl_m1_r;
      tgl_m3_r <= tgl_m2_r;
    end
  end

  // ****************************************************************
  // Frame tracking and status copy for the link.
  // ****************************************************************
  // The link engine is held cleared outside frames; the clear drops
  // only while the bus clock is low, so its release never meets an
  // edge. The status copy changes only while the engine is cleared.
  always_comb begin
    start_evt    = scl_m2_r && sda_m3_r && !sda_m2_r;
    stop_evt     = scl_m2_r && !sda_m3_r && sda_m2_r;
    link_clr_nxt = link_clr_r;
    in_frame_nxt = in_frame_r;
    if (start_evt) begin
      link_clr_nxt = 1'b1;
      in_frame_nxt = 1'b1;
    end else if (stop_evt) begin
      link_clr_nxt = 1'b1;
      in_frame_nxt = 1'b0;
    end else if (in_frame_r && !scl_m2_r) begin
      link_clr_nxt = 1'b0;
    end
    status_x_nxt = link_clr_r ? status_w : status_x_r;
  end

  always_ff @(posedge MCLK_I or posedge rst_m2_r) begin
    if (rst_m2_r) begin
      link_clr_r <= 1'b1;
      in_frame_r <= 1'b0;
      status_x_r <= MS_STAT_RST;
    end else begin
      link_clr_r <= link_clr_nxt;
      in_frame_r <= in_frame_nxt;
      status_x_r <= status_x_nxt;
    end
  end

  // ****************************************************************
  // Status word.
  // ****************************************************************
  generate
    for (genvar g = 0; g < MS_NSW; g++) begin : g_stat
      assign sw_rev[7 - g] = sw_r[g];
    end
  endgenerate

  always_comb begin
    status_w = {sw_rev, 8'h00};
    status_w[MS_GPO_STAT] = HAS_GPO & gpo_r;
  end

  // ****************************************************************
  // Command staging and update.
  // ****************************************************************
  always_comb begin
    cmd_evt      = tgl_m2_r ^ tgl_m3_r;
    mask         = target_mask(link_word[15:8]);
    lvl          = target_level(link_word[15:8]);
    pend_val_nxt = pend_val_r;
    pend_vld_nxt = pend_vld_r;
    pgpo_val_nxt = pgpo_val_r;
    pgpo_vld_nxt = pgpo_vld_r;
    sw_nxt       = sw_r;
    gpo_nxt      = gpo_r;
    if (cmd_evt) begin
      for (int i = 0; i < MS_NSW; i++) begin
        if (mask[i]) begin
          pend_val_nxt[i] = lvl;
          pend_vld_nxt[i] = 1'b1;
        end
      end
      if (mask[8]) begin
        pgpo_val_nxt = lvl;
        pgpo_vld_nxt = 1'b1;
      end
      if (!link_word[RESET_POS]) begin
        sw_nxt       = MS_SW_RST;
        gpo_nxt      = MS_GPO_RST;
        pend_vld_nxt = 8'h00;
        pgpo_vld_nxt = 1'b0;
      end else if (link_word[LOAD_POS]) begin
        for (int i = 0; i < MS_NSW; i++) begin
          sw_nxt[i] = pend_vld_nxt[i] ? pend_val_nxt[i] : sw_r[i];
        end
        gpo_nxt      = pgpo_vld_nxt ? pgpo_val_nxt : gpo_r;
        pend_vld_nxt = 8'h00;
        pgpo_vld_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK_I or posedge rst_m2_r) begin
    if (rst_m2_r) begin
      pend_val_r <= 8'h00;
      pend_vld_r <= 8'h00;
      pgpo_val_r <= 1'b0;
      pgpo_vld_r <= 1'b0;
      sw_r       <= MS_SW_RST;
      gpo_r      <= MS_GPO_RST;
    end else begin
      pend_val_r <= pend_val_nxt;
      pend_vld_r <= pend_vld_nxt;
      pgpo_val_r <= pgpo_val_nxt;
      pgpo_vld_r <= pgpo_vld_nxt;
      sw_r       <= sw_nxt;
      gpo_r      <= gpo_nxt;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign SDA_O            = 1'b0;
  assign SW_CLOSED_O      = sw_r;
  assign GENERAL_OUTPUT_O = HAS_GPO & gpo_r;

endmodule

// *** testbench/ms_switch_properties.sv ***
// Checker of the port behaviour of the switch block.
`timescale 1ns/1ps
module ms_switch_props
  import ms_pkg::*;
#(
  parameter int   LOAD_POS  = MS_LOAD_POS,
  parameter int   RESET_POS = MS_RESET_POS,
  parameter logic HAS_GPO   = 1'b1
)
(
  // Clock and reset.
  input wire logic       MCLK_I,
  input wire logic       RST_I,
  // Bus pins and outputs.
  input wire logic       SCL_I,
  input wire logic       SDA_I,
  input wire logic       SDA_O,
  input wire logic       SDA_OE_O,
  input wire logic [7:0] SW_CLOSED_O,
  input wire logic       GENERAL_OUTPUT_O
);
  // ****************************************************************
  // Frame tracking and cycles since the last bus clock rise.
  // ****************************************************************
  logic       scl_r, scl_nxt, sda_r, sda_nxt, frm_r, frm_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  always_comb begin
    scl_nxt = SCL_I;
    sda_nxt = SDA_I;
    frm_nxt = frm_r;
    if (SCL_I && scl_r && sda_r && !SDA_I) frm_nxt = 1'b1;
    if (SCL_I && scl_r && !sda_r && SDA_I) frm_nxt = 1'b0;
    cnt_nxt = (SCL_I && !scl_r) ? 4'h0 : cnt_r + {3'h0, cnt_r != 4'hf};
  end
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      frm_r <= 1'b0;
      cnt_r <= 4'hf;
    end else begin
      scl_r <= scl_nxt;
      sda_r <= sda_nxt;
      frm_r <= frm_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  // ****************************************************************
  // Assertions.
  // ****************************************************************
  AST_SDA_LOW: assert property (SDA_O == 1'b0)
    else $error("data output not held low");
  AST_RST_OPEN: assert property ($fell(RST_I) |->
    SW_CLOSED_O == 8'h00 && !GENERAL_OUTPUT_O) else $error("not open");
  AST_SW_WHEN: assert property ($changed(SW_CLOSED_O) |->
    frm_r && cnt_r >= 4'h1 && cnt_r < 4'h8) else $error("switch time");
  AST_GPO_WHEN: assert property ($changed(GENERAL_OUTPUT_O) |->
    frm_r && cnt_r >= 4'h1 && cnt_r < 4'h8) else $error("output time");
  AST_TOGETHER: assert property ($changed(SW_CLOSED_O) |=>
    $stable(GENERAL_OUTPUT_O)[*3]) else $error("split update");
  AST_OE_FRAME: assert property (SDA_OE_O |-> frm_r)
    else $error("data driven outside a frame");
  AST_OE_EDGE: assert property ($rose(SDA_OE_O) |-> !SCL_I)
    else $error("data changed with clock high");
  AST_OE_HOLD: assert property ($rose(SDA_OE_O) |-> SDA_OE_O[*5])
    else $error("data drive too short");
  CV_SW: cover property ($changed(SW_CLOSED_O));
  CV_GPO: cover property ($rose(GENERAL_OUTPUT_O));
  CV_OE: cover property ($rose(SDA_OE_O));
endmodule

bind ms_switch_top ms_switch_props #(
  .LOAD_POS (LOAD_POS),
  .RESET_POS(RESET_POS),
  .HAS_GPO  (HAS_GPO)
) i_ms_switch_props (
  .MCLK_I          (MCLK_I),
  .RST_I           (RST_I),
  .SCL_I           (SCL_I),
  .SDA_I           (SDA_I),
  .SDA_O           (SDA_O),
  .SDA_OE_O        (SDA_OE_O),
  .SW_CLOSED_O     (SW_CLOSED_O),
  .GENERAL_OUTPUT_O(GENERAL_OUTPUT_O)
);

// *** testbench/ms_bus_master.sv ***
// Bus master model that drives the serial pins of the switch block.
`timescale 1ns/1ps
module ms_bus_master (
  // Serial pins.
  output logic      scl_o,
  output logic      sda_o,
  input  wire logic sda_i
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // One bit slot: data set in clock low, sampled at the rising edge.
  task automatic slot(input logic b, output logic r);
    #16 sda_o = b;
    #16 scl_o = 1'b1;
    r = sda_i;
    #32 scl_o = 1'b0;
  endtask
  task automatic start();
    #16 sda_o = 1'b1;
    #16 scl_o = 1'b1;
    #48 sda_o = 1'b0;
    #48 scl_o = 1'b0;
  endtask
  task automatic stop();
    #16 sda_o = 1'b0;
    #16 scl_o = 1'b1;
    #48 sda_o = 1'b1;
    #48;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) slot(d[i], r);
    slot(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) slot(1'b1, d[i]);
    slot(~ack, r);
  endtask
endmodule

// *** testbench/tb_mux_switch_update_and_readback.sv ***
// Self-checking testbench of the switch update and readback block.
`timescale 1ns/1ps
module tb_mux_switch_update_and_readback;
  import ms_pkg::*;
  logic        mclk, rst, scl, sda_m, oe, sda_o, general_output, exp_g, pend_g, pend_gm;
  logic [2:0]  asel;
  logic [7:0]  sw, exp_sw, pend_v, pend_m;
  logic [31:0] seed, r;
  logic [15:0] wa, wb, wc;
  int          mismatches, n_compared;
  wire         sda = sda_m & ~oe;
  ms_switch_top i_ms_switch_top (
    .MCLK_I(mclk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE_O(oe), .ADDR_SEL_I(asel),
    .SW_CLOSED_O(sw), .GENERAL_OUTPUT_O(general_output));
  ms_bus_master i_ms_bus_master (.scl_o(scl), .sda_o(sda_m), .sda_i(sda));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic stage(input int i, input logic l);
    pend_v[i] = l;
    pend_m[i] = 1'b1;
  endtask
  // Reference model of one command word.
  task automatic model(input logic [7:0] c, input logic [7:0] k);
    logic [6:0] s;
    s = c[6:0];
    if (!k[MS_RESET_POS]) begin
      {exp_sw, exp_g, pend_m, pend_gm} = '0;
      return;
    end
    if (s <= 7'h01) for (int i = s; i < 8; i += 2) stage(i, c[7]);
    else if (s <= 7'h09) stage(s - 2, c[7]);
    else if (s >= 7'h0e && s <= 7'h11) begin
      stage(2 * (s - 14), 1'b0);
      stage(2 * (s - 14) + 1, 1'b0);
    end else if (s == 7'h14) {pend_g, pend_gm} = {c[7], 1'b1};
    else if (s == 7'h1f && !c[7]) for (int i = 0; i < 8; i++) stage(i, 0);
    if (k[MS_LOAD_POS]) begin
      exp_sw = (exp_sw & ~pend_m) | (pend_v & pend_m);
      if (pend_gm) exp_g = pend_g;
      {pend_m, pend_gm} = '0;
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] w[$]);
    logic ack;
    logic hit;
    hit = (a == asel);
    i_ms_bus_master.start();
    i_ms_bus_master.wbyte({4'ha, a, 1'b0}, ack);
    check({15'h0000, ack}, {15'h0000, hit});
    foreach (w[i]) if (hit) begin
      i_ms_bus_master.wbyte(w[i][15:8], ack);
      i_ms_bus_master.wbyte(w[i][7:0], ack);
      model(w[i][15:8], w[i][7:0]);
    end
    i_ms_bus_master.stop();
    repeat (10) @(negedge mclk);
    check({sw, 7'h00, general_output}, {exp_sw, 7'h00, exp_g});
  endtask
  task automatic rd();
    logic        ack;
    logic [7:0]  hi, lo;
    logic [15:0] e;
    i_ms_bus_master.start();
    i_ms_bus_master.wbyte({4'ha, asel, 1'b1}, ack);
    check({15'h0000, ack}, 16'h0001);
    i_ms_bus_master.rbyte(1'b1, hi);
    i_ms_bus_master.rbyte(1'b0, lo);
    i_ms_bus_master.stop();
    e = 16'h0000;
    for (int i = 0; i < 8; i++) e[15 - i] = exp_sw[i];
    e[3] = exp_g;
    check({hi, lo}, e);
  endtask
  initial begin
    #900000;
    mismatches++;
    end_of_test();
  end
  initial begin
    {rst, asel, seed} = {1'b1, 3'h5, 32'h256c};
    {mismatches, n_compared, exp_sw, exp_g, pend_m, pend_gm} = '0;
    {pend_v, pend_g} = '0;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    repeat (5) @(negedge mclk);
    check({sw, 7'h00, general_output}, 16'h0000);
    rd();
    $display("test power-up done");
    for (int i = 0; i < 64; i++) begin
      r = rnd();
      wr(asel, '{{i[0], 2'b00, i[5:1], r[7:2], 2'b11}});
      rd();
    end
    $display("test command codes done");
    for (int g = 0; g < 6; g++) begin
      r = rnd();
      wa = {r[7], 2'b00, r[4:0], r[23:18], 2'b10};
      wb = wa ^ 16'h8000;
      wc = {r[15], 2'b00, r[12:8], r[23:18], 2'b11};
      if (g[0]) begin
        wr(asel, '{wa});
        wr(asel, '{wb});
        wr(asel, '{wc});
      end else wr(asel, '{wa, wb, wc});
      rd();
    end
    $display("test grouped update done");
    wr(asel, '{16'h9403});
    wr(asel, '{16'h8202});
    wr(asel, '{16'h8001});
    wr(asel, '{16'h0a03});
    rd();
    $display("test soft reset done");
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      wr(asel ^ {r[2:1], 1'b1}, '{16'h8003});
      asel = r[5:3];
      repeat (4) @(negedge mclk);
      wr(asel, '{{r[15], 2'b00, r[12:8], 8'h03}});
      rd();
    end
    $display("test address done");
    wr(asel, '{16'h9403});
    rst = 1'b1;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    {exp_sw, exp_g, pend_m, pend_gm} = '0;
    repeat (5) @(negedge mclk);
    check({sw, 7'h00, general_output}, 16'h0000);
    rd();
    $display("test second reset done");
    end_of_test();
  end
endmodule
